// ==== lpr_pkg.sv ====
package lpr_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] OFS_STATUS = 16'h0010;
  localparam logic [15:0] OFS_SETPEND = 16'h0040;
  localparam logic [15:0] OFS_SETPEND_HI = 16'h0044;
  localparam logic [15:0] OFS_CFGBASE = 16'h0070;
  localparam logic [15:0] OFS_CFGBASE_HI = 16'h0074;
  localparam logic STATUS_PRESENT = 1'b1;
  // ---------------------------------------------------------------
  // Table base field layout
  // ---------------------------------------------------------------
  localparam int OUTER_LSB = 56;
  localparam int PA_LSB = 12;
  localparam int PA_MSB = 51;
  localparam int SHARE_LSB = 10;
  localparam int INNER_LSB = 7;
  localparam int IDW_LSB = 0;
  localparam int PA_IMPL_BITS = 48;
  localparam int PA_KEEP = PA_IMPL_BITS - PA_LSB;
  localparam logic [1:0] SHARE_NONE = 2'h0;
  localparam logic [1:0] SHARE_RSVD = 2'h3;
  localparam logic [2:0] OUTER_RST = 3'h0;
  localparam logic [2:0] INNER_RST = 3'h0;
  localparam logic [4:0] IDW_RST = 5'h00;
  localparam logic [4:0] IDW_MIN = 5'h0d;
  // ---------------------------------------------------------------
  // Error status flags
  // ---------------------------------------------------------------
  localparam int ERR_WRITE_RO = 3;
  localparam int ERR_READ_WO = 2;
  localparam int ERR_WRITE_RSVD = 1;
  localparam int ERR_READ_RSVD = 0;
  localparam logic [3:0] ERR_RST = 4'h0;
  // ---------------------------------------------------------------
  // Pending store
  // ---------------------------------------------------------------
  localparam int PEND_DEPTH = 64;
  localparam int PEND_IDX_W = 6;
  localparam logic [31:0] PEND_BASE = 32'h0000_2000;
  localparam logic [31:0] PEND_END = 32'h0000_2040;

  // Returns the narrower of two identifier widths
  function automatic logic [4:0] lpr_min_idw(input logic [4:0] a,
                                             input logic [4:0] b);
    lpr_min_idw = (a > b) ? b : a;
  endfunction

  // Zero-extends the low word when the access is 32 bits wide
  function automatic logic [63:0] lpr_wdata(input logic [63:0] d,
                                            input logic wide);
    lpr_wdata = wide ? d : {32'h0000_0000, d[31:0]};
  endfunction
endpackage

// ==== lpr_pend_tracker.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpr_pend_tracker (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Set request
  input wire logic set_valid_in,
  input wire logic [31:0] set_number_in,
  input wire logic [4:0] id_bits_in,
  input wire logic enable_in,
  // Clear from interrupt delivery
  input wire logic clr_valid_in,
  input wire logic [31:0] clr_number_in,
  // Status
  output logic accepted_out,
  output logic [lpr_pkg::PEND_DEPTH-1:0] pending_out
);
  import lpr_pkg::*;

  logic [PEND_DEPTH-1:0] pend_q;
  logic [PEND_DEPTH-1:0] pend_d;
  logic [PEND_DEPTH-1:0] set_mask;
  logic [PEND_DEPTH-1:0] clr_mask;
  logic [31:0] set_off;
  logic [31:0] clr_off;
  logic [31:0] limit_mask;
  logic set_in_range;
  logic clr_in_range;
  logic width_ok;
  logic set_impl;

  // Every number must fit the effective width; below 13 nothing fits
  assign width_ok = (id_bits_in >= IDW_MIN);
  assign limit_mask = ~((32'h0000_0002 << id_bits_in) - 32'h0000_0001);
  assign set_off = set_number_in - PEND_BASE;
  assign clr_off = clr_number_in - PEND_BASE;
  assign set_in_range = (set_number_in >= PEND_BASE) &&
                        (set_number_in < PEND_END);
  assign clr_in_range = (clr_number_in >= PEND_BASE) &&
                        (clr_number_in < PEND_END);
  assign set_impl = set_in_range && width_ok &&
                    ((set_number_in & limit_mask) == 32'h0000_0000);
  assign accepted_out = set_valid_in && enable_in && set_impl &&
                        !pend_q[set_off[PEND_IDX_W-1:0]];
  assign set_mask = accepted_out ?
                    ({{(PEND_DEPTH-1){1'b0}}, 1'b1} <<
                     set_off[PEND_IDX_W-1:0]) : '0;
  assign clr_mask = (clr_valid_in && clr_in_range) ?
                    ({{(PEND_DEPTH-1){1'b0}}, 1'b1} <<
                     clr_off[PEND_IDX_W-1:0]) : '0;
  // Set wins over a same-cycle delivery clear; a set of a number already pending is refused, so the clear removes it
  assign pend_d = (pend_q & ~clr_mask) | set_mask;
  assign pending_out = pend_q;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end
endmodule
`default_nettype wire

// ==== lpr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpr_regs (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Register access port
  input wire logic reg_req_in,
  input wire logic reg_wr_in,
  input wire logic reg_wide_in,
  input wire logic reg_secure_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [63:0] reg_wdata_in,
  output logic reg_ack_out,
  output logic [63:0] reg_rdata_out,
  // System configuration
  input wire logic [4:0] global_identifier_width_in,
  input wire logic message_interrupt_enable_in,
  input wire logic security_disable_in,
  input wire logic config_table_read_only_in,
  // Pending delivery
  input wire logic pending_clear_in,
  input wire logic [31:0] pending_clear_number_in,
  output logic set_pending_strobe_out,
  output logic [31:0] interrupt_number_out,
  output logic [lpr_pkg::PEND_DEPTH-1:0] pending_out,
  // Table attributes
  output logic [4:0] effective_id_bits_out,
  output logic [1:0] shareability_out
);
  import lpr_pkg::*;

  // ---------------------------------------------------------------
  // Table base storage
  // ---------------------------------------------------------------
  logic [2:0] outer_q;
  logic [2:0] outer_d;
  logic [PA_KEEP-1:0] pa_q;
  logic [PA_KEEP-1:0] pa_d;
  logic [1:0] share_q;
  logic [1:0] share_d;
  logic [2:0] inner_q;
  logic [2:0] inner_d;
  logic [4:0] idw_q;
  logic [4:0] idw_d;

  // ---------------------------------------------------------------
  // Banked error status
  // ---------------------------------------------------------------
  logic [3:0] err_s_q;
  logic [3:0] err_s_d;
  logic [3:0] err_ns_q;
  logic [3:0] err_ns_d;

  // ---------------------------------------------------------------
  // Response and strobe flops
  // ---------------------------------------------------------------
  logic ack_q;
  logic [63:0] rdata_q;
  logic [63:0] rdata_d;
  logic strobe_q;
  logic [31:0] number_q;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic rd;
  logic wr;
  logic hit_status;
  logic hit_setp_lo;
  logic hit_setp_hi;
  logic hit_cfg_lo;
  logic hit_cfg_hi;
  logic hit_any;
  logic use_secure_bank;
  logic [63:0] wdata;
  logic [63:0] cfg_word;
  logic [63:0] cfg_new;
  logic cfg_write;
  logic cfg_ro;
  logic status_write;
  logic [3:0] err_set;
  logic [3:0] err_clr;
  logic [3:0] err_view;
  logic [63:0] status_word;
  logic setp_write;
  logic [31:0] setp_number;
  logic setp_accepted;
  logic [4:0] eff_idw;

  assign rd = reg_req_in && !reg_wr_in;
  assign wr = reg_req_in && reg_wr_in;
  assign hit_status = (reg_addr_in == OFS_STATUS);
  assign hit_setp_lo = (reg_addr_in == OFS_SETPEND);
  // 64-bit access must be aligned; upper halves reached only by 32-bit
  assign hit_setp_hi = (reg_addr_in == OFS_SETPEND_HI) && !reg_wide_in;
  assign hit_cfg_lo = (reg_addr_in == OFS_CFGBASE);
  assign hit_cfg_hi = (reg_addr_in == OFS_CFGBASE_HI) && !reg_wide_in;
  assign hit_any = (hit_status && STATUS_PRESENT) || hit_setp_lo ||
                   hit_setp_hi || hit_cfg_lo || hit_cfg_hi;
  // With one security state only the secure copy is in use
  assign use_secure_bank = reg_secure_in || security_disable_in;
  assign wdata = lpr_wdata(reg_wdata_in, reg_wide_in);

  // ---------------------------------------------------------------
  // Table base register
  // ---------------------------------------------------------------
  assign cfg_word = {5'h00, outer_q, 4'h0,
                     {(PA_MSB - PA_IMPL_BITS + 1){1'b0}}, pa_q,
                     share_q, inner_q, 2'h0, idw_q};
  // 32-bit writes replace only their own half of the word
  assign cfg_new = reg_wide_in ? reg_wdata_in :
                   (hit_cfg_hi ? {reg_wdata_in[31:0], cfg_word[31:0]} :
                                 {cfg_word[63:32], reg_wdata_in[31:0]});
  assign cfg_ro = config_table_read_only_in;
  assign cfg_write = wr && (hit_cfg_lo || hit_cfg_hi) && !cfg_ro;
  // Outer and inner are plain storage, software programmable
  assign outer_d = cfg_write ?
                   cfg_new[OUTER_LSB+2:OUTER_LSB] : outer_q;
  assign pa_d = cfg_write ? cfg_new[PA_IMPL_BITS-1:PA_LSB] : pa_q;
  // Reserved share code is folded so readback shows the value used
  assign share_d = !cfg_write ? share_q :
                   ((cfg_new[SHARE_LSB+1:SHARE_LSB] == SHARE_RSVD) ?
                    SHARE_NONE : cfg_new[SHARE_LSB+1:SHARE_LSB]);
  assign inner_d = cfg_write ?
                   cfg_new[INNER_LSB+2:INNER_LSB] : inner_q;
  assign idw_d = cfg_write ? cfg_new[IDW_LSB+4:IDW_LSB] : idw_q;
  assign eff_idw = lpr_min_idw(idw_q, global_identifier_width_in);

  // ---------------------------------------------------------------
  // Set-pending register
  // ---------------------------------------------------------------
  assign setp_write = wr && hit_setp_lo;
  // Upper word is reserved and never reaches the number
  assign setp_number = wdata[31:0];

  lpr_pend_tracker u_pend (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .set_valid_in(setp_write),
    .set_number_in(setp_number),
    .id_bits_in(eff_idw),
    .enable_in(message_interrupt_enable_in),
    .clr_valid_in(pending_clear_in),
    .clr_number_in(pending_clear_number_in),
    .accepted_out(setp_accepted),
    .pending_out(pending_out)
  );

  // ---------------------------------------------------------------
  // Error detection
  // ---------------------------------------------------------------
  assign err_set[ERR_WRITE_RO] = wr && (hit_cfg_lo || hit_cfg_hi) &&
                                 cfg_ro;
  assign err_set[ERR_READ_WO] = rd &&
                                (hit_setp_lo || hit_setp_hi);
  assign err_set[ERR_WRITE_RSVD] = wr && !hit_any;
  assign err_set[ERR_READ_RSVD] = rd && !hit_any;
  assign status_write = wr && hit_status && STATUS_PRESENT;
  assign err_clr = status_write ? wdata[3:0] : 4'h0;
  // A new event in the clearing cycle survives the clear
  assign err_s_d = !STATUS_PRESENT ? ERR_RST :
                   use_secure_bank ? ((err_s_q & ~err_clr) | err_set) :
                   err_s_q;
  assign err_ns_d = !STATUS_PRESENT ? ERR_RST :
                    !use_secure_bank ? ((err_ns_q & ~err_clr) | err_set) :
                    err_ns_q;
  assign err_view = use_secure_bank ? err_s_q : err_ns_q;
  assign status_word = STATUS_PRESENT ?
                       {60'h0, err_view} : 64'h0;

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = 64'h0;
    if (rd) begin
      if (hit_status) begin
        rdata_d = status_word;
      end else if (hit_cfg_lo) begin
        rdata_d = reg_wide_in ? cfg_word : {32'h0, cfg_word[31:0]};
      end else if (hit_cfg_hi) begin
        rdata_d = {32'h0, cfg_word[63:32]};
      end else begin
        // Write-only and reserved locations return zero
        rdata_d = 64'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      outer_q <= OUTER_RST;
      pa_q <= '0;
      share_q <= SHARE_NONE;
      inner_q <= INNER_RST;
      idw_q <= IDW_RST;
    end else begin
      outer_q <= outer_d;
      pa_q <= pa_d;
      share_q <= share_d;
      inner_q <= inner_d;
      idw_q <= idw_d;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      err_s_q <= ERR_RST;
      err_ns_q <= ERR_RST;
    end else begin
      err_s_q <= err_s_d;
      err_ns_q <= err_ns_d;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q <= 1'b0;
      rdata_q <= 64'h0;
      strobe_q <= 1'b0;
      number_q <= 32'h0;
    end else begin
      ack_q <= reg_req_in;
      rdata_q <= rdata_d;
      strobe_q <= setp_accepted;
      number_q <= setp_accepted ? setp_number : number_q;
    end
  end

  assign reg_ack_out = ack_q;
  assign reg_rdata_out = rdata_q;
  assign set_pending_strobe_out = strobe_q;
  assign interrupt_number_out = number_q;
  assign effective_id_bits_out = eff_idw;
  assign shareability_out = share_q;
endmodule
`default_nettype wire

// ==== lpr_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpr_properties (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic reg_req_in,
  input wire logic reg_wr_in,
  input wire logic reg_wide_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic reg_ack_out,
  input wire logic [63:0] reg_rdata_out,
  // Configuration and results
  input wire logic [4:0] global_identifier_width_in,
  input wire logic message_interrupt_enable_in,
  input wire logic set_pending_strobe_out,
  input wire logic [31:0] interrupt_number_out,
  input wire logic [lpr_pkg::PEND_DEPTH-1:0] pending_out,
  input wire logic [4:0] effective_id_bits_out,
  input wire logic [1:0] shareability_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  wire logic rd_wo = reg_req_in && !reg_wr_in && reg_addr_in == 16'h0040;
  wire logic rd_base = reg_req_in && !reg_wr_in && reg_wide_in &&
    reg_addr_in == 16'h0070;
  wire logic wr_set = reg_req_in && reg_wr_in && reg_addr_in == 16'h0040;
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_ack;
    1'b1 |=> reg_ack_out == $past(reg_req_in);
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_idw;
    effective_id_bits_out <= global_identifier_width_in;
  endproperty
  a_idw: assert property (p_idw) else $error("id width cap");
  property p_cause;
    set_pending_strobe_out |-> $past(wr_set && message_interrupt_enable_in);
  endproperty
  a_cause: assert property (p_cause) else $error("stray set");
  property p_num;
    set_pending_strobe_out |-> interrupt_number_out inside
      {[32'h2000:32'h203f]} && pending_out[interrupt_number_out[5:0]];
  endproperty
  a_num: assert property (p_num) else $error("set number");
  property p_eff;
    set_pending_strobe_out |-> $past(effective_id_bits_out) >= 5'h0d;
  endproperty
  a_eff: assert property (p_eff) else $error("set below width");
  property p_hold;
    !set_pending_strobe_out |-> $stable(interrupt_number_out);
  endproperty
  a_hold: assert property (p_hold) else $error("number moved");
  property p_wo_rd;
    rd_wo |=> reg_rdata_out == 64'h0;
  endproperty
  a_wo_rd: assert property (p_wo_rd) else $error("wo read data");
  property p_base_rsv;
    rd_base |=> reg_rdata_out[63:59] == 5'h0 && reg_rdata_out[55:48] ==
      8'h0 && reg_rdata_out[6:5] == 2'h0 && reg_rdata_out[11:10] != 2'h3;
  endproperty
  a_base_rsv: assert property (p_base_rsv) else $error("base rsv");
  property p_share;
    shareability_out != 2'h3;
  endproperty
  a_share: assert property (p_share) else $error("share code");
  c_set: cover property (set_pending_strobe_out);
  c_wo_rd: cover property (rd_wo);
  c_base_rd: cover property (rd_base);
endmodule
`default_nettype wire

// ==== lpr_sw_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpr_sw_model (
  // Clock
  input wire logic clk_sys_in,
  // Access request
  output logic req_out,
  output logic wr_out,
  output logic wide_out,
  output logic sec_out,
  output logic [15:0] addr_out,
  output logic [63:0] wdata_out,
  // Answer
  input wire logic ack_in,
  input wire logic [63:0] rdata_in
);
  initial {req_out, wr_out, wide_out, sec_out, addr_out, wdata_out} = '0;
  task automatic xfer(input logic w, wd, s, input logic [15:0] a,
                      input logic [63:0] d, output logic [63:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    req_out <= 1'b1;
    wr_out <= w;
    wide_out <= wd;
    sec_out <= s;
    // Single redistributor, so the one table base is the shared copy
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_sys_in);
    req_out <= 1'b0;
    // Released address and data lines never keep a stale value
    addr_out <= ~a;
    wdata_out <= ~d;
    @(negedge clk_sys_in);
    while (ack_in !== 1'b1 && n < 4) begin
      n++;
      @(negedge clk_sys_in);
    end
    q = (ack_in === 1'b1) ? rdata_in : 64'hdead_beef_dead_beef;
  endtask
endmodule
`default_nettype wire

// ==== tb_lpr.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lpr_pkg::*;
  logic clk_sys_in, rst_b_in, reg_req_in, reg_wr_in, reg_wide_in;
  logic reg_secure_in, reg_ack_out, set_pending_strobe_out;
  logic [15:0] reg_addr_in;
  logic [63:0] reg_wdata_in, reg_rdata_out, q, pending_out;
  logic [4:0] global_identifier_width_in, effective_id_bits_out;
  logic message_interrupt_enable_in, security_disable_in;
  logic config_table_read_only_in, pending_clear_in;
  logic [31:0] pending_clear_number_in, interrupt_number_out;
  logic [1:0] shareability_out;
  int failures, n_tests, n_strobe, n0;
  lpr_regs DUT (.clk_sys_in, .rst_b_in, .reg_req_in, .reg_wr_in,
    .reg_wide_in, .reg_secure_in, .reg_addr_in, .reg_wdata_in, .reg_ack_out,
    .reg_rdata_out, .global_identifier_width_in, .message_interrupt_enable_in,
    .security_disable_in, .config_table_read_only_in, .pending_clear_in,
    .pending_clear_number_in, .set_pending_strobe_out, .interrupt_number_out,
    .pending_out, .effective_id_bits_out, .shareability_out);
  lpr_sw_model sw (.clk_sys_in, .req_out(reg_req_in), .wr_out(reg_wr_in),
    .wide_out(reg_wide_in), .sec_out(reg_secure_in), .addr_out(reg_addr_in),
    .wdata_out(reg_wdata_in), .ack_in(reg_ack_out), .rdata_in(reg_rdata_out));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [63:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic wd, input logic [15:0] a,
                    input logic [63:0] d);
    sw.xfer(1'b1, wd, 1'b1, a, d, q);
    // Writes answer with zero data; a missing ack leaves the sentinel
    chk(64'h0, q);
  endtask
  task automatic rd(input logic s, input logic [15:0] a);
    sw.xfer(1'b0, 1'b1, s, a, 64'h0, q);
  endtask
  task automatic give_verdict;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(1'b1, 16'h0070);
    chk(64'h0, q);
    rd(1'b1, 16'h0010);
    chk(64'h0, q);
    $display("t_reset done");
  endtask
  task automatic t_table;
    wr(1'b1, 16'h0070, '1);
    rd(1'b0, 16'h0070);
    chk(64'h0700_ffff_ffff_f39f, q);
    chk(64'h0f, {59'h0, effective_id_bits_out});
    // Zero upper data would clear the high half if it leaked
    wr(1'b0, 16'h0070, 64'h0000_0000_0000_368d);
    rd(1'b1, 16'h0070);
    chk(64'h0700_ffff_0000_368d, q);
    wr(1'b0, 16'h0074, 64'hffff_ffff_0300_00ab);
    rd(1'b1, 16'h0070);
    chk(64'h0300_00ab_0000_368d, q);
    chk(64'h1, {62'h0, shareability_out});
    chk(64'h0d, {59'h0, effective_id_bits_out});
    $display("t_table done");
  endtask
  task automatic t_setpend;
    n0 = n_strobe;
    wr(1'b0, 16'h0040, 64'hffff_ffff_0000_2005);
    chk(64'h2005, {32'h0, interrupt_number_out});
    chk(64'h20, pending_out);
    wr(1'b1, 16'h0040, 64'h2005);
    wr(1'b1, 16'h0040, 64'h2040);
    @(posedge clk_sys_in);
    message_interrupt_enable_in <= 1'b0;
    wr(1'b1, 16'h0040, 64'h2006);
    @(posedge clk_sys_in);
    message_interrupt_enable_in <= 1'b1;
    wr(1'b1, 16'h0070, 64'h0c);
    wr(1'b1, 16'h0040, 64'h2007);
    chk(64'h20, pending_out);
    @(posedge clk_sys_in);
    pending_clear_in <= 1'b1;
    pending_clear_number_in <= 32'h2005;
    @(posedge clk_sys_in);
    pending_clear_in <= 1'b0;
    rd(1'b1, 16'h0070);
    chk(64'h0c, q);
    chk(64'h0, pending_out);
    chk(64'h1, 64'(n_strobe - n0));
    $display("t_setpend done");
  endtask
  task automatic t_status;
    rd(1'b1, 16'h0040);
    chk(64'h0, q);
    rd(1'b1, 16'h0020);
    chk(64'h0, q);
    wr(1'b1, 16'h0020, '1);
    @(posedge clk_sys_in);
    config_table_read_only_in <= 1'b1;
    wr(1'b1, 16'h0070, 64'h0);
    rd(1'b1, 16'h0070);
    chk(64'h0c, q);
    rd(1'b1, 16'h0010);
    chk(64'h0f, q);
    rd(1'b0, 16'h0010);
    chk(64'h0, q);
    wr(1'b1, 16'h0010, 64'hffff_fff5);
    rd(1'b1, 16'h0010);
    chk(64'h0a, q);
    // One security state: a non-secure access sees the secure copy
    @(posedge clk_sys_in);
    security_disable_in <= 1'b1;
    rd(1'b0, 16'h0010);
    chk(64'h0a, q);
    $display("t_status done");
  endtask
  // ---------------------------------------------------------------
  // Clock, reset, sequence
  // ---------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    if (set_pending_strobe_out === 1'b1) n_strobe++;
  end
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
  initial begin
    {failures, n_tests, n_strobe} = '0;
    rst_b_in = 1'b0;
    global_identifier_width_in = 5'h0f;
    message_interrupt_enable_in = 1'b1;
    {security_disable_in, config_table_read_only_in} = 2'b00;
    pending_clear_in = 1'b0;
    pending_clear_number_in = 32'h0;
    repeat (20) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_table();
    t_setpend();
    t_status();
    give_verdict();
  end
endmodule
bind lpr_regs lpr_properties u_prop (.clk_sys_in, .rst_b_in, .reg_req_in,
  .reg_wr_in, .reg_wide_in, .reg_addr_in, .reg_ack_out, .reg_rdata_out,
  .global_identifier_width_in, .message_interrupt_enable_in,
  .set_pending_strobe_out, .interrupt_number_out, .pending_out,
  .effective_id_bits_out, .shareability_out);
`default_nettype wire
